// ### rtl/pfm_pin_mux.sv
// pin function multiplexer: select registers on a register bus and the per-pin routing
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module pfm_pin_mux
    import pfm_pkg::*;
(
    // clock, reset, clock enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register bus
    input wire pfm_axil_req_type axil_req,
    output pfm_axil_rsp_type axil_rsp,
    // port-0 low pads
    input wire logic [PFM_P0_PINS-1:0] p0_pad_in,
    output logic [PFM_P0_PINS-1:0] p0_pad_out,
    output logic [PFM_P0_PINS-1:0] p0_pad_oe,
    // port-0 general purpose I/O side
    input wire logic [PFM_P0_PINS-1:0] port0_gpio_out,
    input wire logic [PFM_P0_PINS-1:0] port0_direction_bits,
    output logic [PFM_P0_PINS-1:0] port0_gpio_in,
    // port-0 peripheral side, index 0..2 for codes 01, 10, 11
    input wire logic [PFM_P0_PINS-1:0][2:0] p0_alt_out,
    input wire logic [PFM_P0_PINS-1:0][2:0] p0_alt_oe,
    output logic [PFM_P0_PINS-1:0][2:0] p0_alt_in,
    output logic [PFM_P0_PINS-1:0] p0_analog_path_en,
    // port-0 high routing word for the high-pin multiplexer
    output logic [31:0] port0_high_select,
    // port-1 pads 16..31
    input wire logic [PFM_P1_PINS-1:0] p1_pad_in,
    output logic [PFM_P1_PINS-1:0] p1_pad_out,
    output logic [PFM_P1_PINS-1:0] p1_pad_oe,
    // port-1 general purpose I/O side
    input wire logic [PFM_P1_PINS-1:0] port1_gpio_out,
    input wire logic [PFM_P1_PINS-1:0] port1_direction_bits,
    output logic [PFM_P1_PINS-1:0] port1_gpio_in,
    // port-1 trace and debug side
    input wire logic [PFM_P1_PINS-1:0] p1_dbg_out,
    input wire logic [PFM_P1_PINS-1:0] p1_dbg_oe,
    output logic [PFM_P1_PINS-1:0] p1_dbg_in,
    output logic jtag_tms,
    output logic jtag_trst,
    output logic debug_port_en,
    output logic trace_port_en
);

    localparam int P20 = PFM_P1_PIN20 - PFM_P1_FIRST;
    localparam int P26 = PFM_P1_PIN26 - PFM_P1_FIRST;
    localparam int P30 = PFM_P1_PIN30 - PFM_P1_FIRST;
    localparam int P31 = PFM_P1_PIN31 - PFM_P1_FIRST;

    pfm_state_type cur;
    pfm_state_type next_cur;
    logic wr_fire;
    logic aw_take;
    logic w_take;
    logic ar_take;

    // merge a written word into a register under the byte strobes
    function automatic logic [31:0] pfm_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    // ready only while the clock enable lets the state move, so no beat is lost
    assign axil_rsp.awready = ce & ~cur.aw_held & ~cur.bvalid;
    assign axil_rsp.wready = ce & ~cur.w_held & ~cur.bvalid;
    assign axil_rsp.arready = ce & ~cur.rvalid;
    assign axil_rsp.bvalid = cur.bvalid;
    assign axil_rsp.bresp = cur.bresp;
    assign axil_rsp.rvalid = cur.rvalid;
    assign axil_rsp.rdata = cur.rdata;
    assign axil_rsp.rresp = cur.rresp;

    assign aw_take = axil_req.awvalid & axil_rsp.awready;
    assign w_take = axil_req.wvalid & axil_rsp.wready;
    assign ar_take = axil_req.arvalid & axil_rsp.arready;
    // address and data may arrive in either order; write happens once both are held
    assign wr_fire = ce & cur.aw_held & cur.w_held & ~cur.bvalid;

    // next-state logic: synchronisers, strap capture, register bus
    always_comb begin
        next_cur = cur;
        if (ce) begin
            // two-stage synchronisers; stage one feeds only stage two
            next_cur.p0_s1 = p0_pad_in;
            next_cur.p0_s2 = cur.p0_s1;
            next_cur.p1_s1 = p1_pad_in;
            next_cur.p1_s2 = cur.p1_s1;

            // straps are sampled once the synchronisers hold settled pad levels;
            // both stages reset to one, so stage two shows a real pad level only from the second edge
            case (cur.strap)
                PFM_STRAP_WAIT1: begin
                    next_cur.strap = PFM_STRAP_WAIT2;
                end
                PFM_STRAP_WAIT2: begin
                    next_cur.strap = PFM_STRAP_WAIT3;
                end
                PFM_STRAP_WAIT3: begin
                    next_cur.sel2[PFM_SEL2_TRACE_BIT] = ~cur.p1_s2[P20];
                    next_cur.sel2[PFM_SEL2_DEBUG_BIT] = ~cur.p1_s2[P26];
                    next_cur.strap = PFM_STRAP_DONE;
                end
                PFM_STRAP_DONE: begin
                    next_cur.strap = PFM_STRAP_DONE;
                end
                default: begin
                    next_cur.strap = PFM_STRAP_DONE;
                end
            endcase

            // write channel capture
            if (aw_take) begin
                next_cur.aw_held = 1'b1;
                next_cur.aw_addr = axil_req.awaddr;
            end
            if (w_take) begin
                next_cur.w_held = 1'b1;
                next_cur.w_data = axil_req.wdata;
                next_cur.w_strb = axil_req.wstrb;
            end

            // the write lands at this edge, so routing follows in the same cycle as bvalid
            if (wr_fire) begin
                next_cur.aw_held = 1'b0;
                next_cur.w_held = 1'b0;
                next_cur.bvalid = 1'b1;
                next_cur.bresp = PFM_RESP_OKAY;
                case (cur.aw_addr)
                    PFM_ADDR_SEL0: begin
                        next_cur.sel0 = pfm_merge(cur.sel0, cur.w_data, cur.w_strb);
                    end
                    PFM_ADDR_SEL1: begin
                        next_cur.sel1 = pfm_merge(cur.sel1, cur.w_data, cur.w_strb);
                    end
                    PFM_ADDR_SEL2: begin
                        // reserved bits never store, so they read back zero
                        next_cur.sel2 = pfm_merge(next_cur.sel2, cur.w_data, cur.w_strb) & PFM_SEL2_WMASK;
                    end
                    default: begin
                        next_cur.bresp = PFM_RESP_DECERR;
                    end
                endcase
            end else if (cur.bvalid && axil_req.bready) begin
                next_cur.bvalid = 1'b0;
            end

            // read channel: one cycle from address to data
            if (ar_take) begin
                next_cur.rvalid = 1'b1;
                next_cur.rresp = PFM_RESP_OKAY;
                case (axil_req.araddr)
                    PFM_ADDR_SEL0: begin
                        next_cur.rdata = cur.sel0;
                    end
                    PFM_ADDR_SEL1: begin
                        next_cur.rdata = cur.sel1;
                    end
                    PFM_ADDR_SEL2: begin
                        next_cur.rdata = cur.sel2;
                    end
                    default: begin
                        next_cur.rdata = 32'h0000_0000;
                        next_cur.rresp = PFM_RESP_DECERR;
                    end
                endcase
            end else if (cur.rvalid && axil_req.rready) begin
                next_cur.rvalid = 1'b0;
            end
        end
    end

    // state register; reset restores every default routing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.sel0 <= PFM_RST_SEL0;
            cur.sel1 <= PFM_RST_SEL1;
            cur.sel2 <= PFM_RST_SEL2;
            cur.bresp <= PFM_RESP_OKAY;
            cur.rresp <= PFM_RESP_OKAY;
            cur.strap <= PFM_STRAP_WAIT1;
            cur.p0_s1 <= PFM_RST_SYNC;
            cur.p0_s2 <= PFM_RST_SYNC;
            cur.p1_s1 <= PFM_RST_SYNC;
            cur.p1_s2 <= PFM_RST_SYNC;
        end else begin
            cur <= next_cur;
        end
    end

    assign port0_high_select = cur.sel1;

    default clocking pfm_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // port-0 low pins: a two-bit code per pin picks at most one owner
    for (genvar p = 0; p < PFM_P0_PINS; p++) begin : g_p0
        logic [1:0] code;
        logic [1:0] alt;
        logic dead;
        assign code = cur.sel0[2*p +: 2];
        assign alt = code - 2'h1;
        // analog and reserved codes never drive the pad digitally
        assign dead = (code == PFM_CODE_ALT3) && (PFM_ANALOG_PINS[p] || PFM_RESERVED_PINS[p]);

        // output path; per-pin alternates are wired by index as listed in the pin table
        always_comb begin
            if (code == PFM_CODE_GPIO) begin
                p0_pad_out[p] = port0_gpio_out[p];
                p0_pad_oe[p] = port0_direction_bits[p];
            end else if (dead) begin
                p0_pad_out[p] = 1'b0;
                p0_pad_oe[p] = 1'b0;
            end else begin
                p0_pad_out[p] = p0_alt_out[p][alt];
                p0_pad_oe[p] = p0_alt_oe[p][alt];
            end
        end

        // input path: only the selected owner sees the pad, the rest read low
        assign port0_gpio_in[p] = (code == PFM_CODE_GPIO) ? cur.p0_s2[p] : 1'b0;
        for (genvar k = 0; k < 3; k++) begin : g_alt
            assign p0_alt_in[p][k] = (code == 2'(k + 1)) && !dead ? cur.p0_s2[p] : 1'b0;
        end

        // the converter tap bypasses this block; only the interface circuit is switched
        assign p0_analog_path_en[p] = PFM_ANALOG_PINS[p] && (code == PFM_CODE_ALT3);

        AST_P0_GPIO_DIR: assert property ((code == PFM_CODE_GPIO) |-> (p0_pad_oe[p] == port0_direction_bits[p]))
            else $error("gpio pin oe not following direction bit");
        AST_P0_ALT_OE: assert property ((code == 2'h1) |-> (p0_pad_oe[p] == p0_alt_oe[p][0]) && (p0_pad_out[p] == p0_alt_out[p][0]))
            else $error("first alternate does not own the pin");
        AST_P0_EXCL: assert property ((p0_alt_in[p] != 3'h0) |-> !port0_gpio_in[p] && $onehot(p0_alt_in[p]))
            else $error("more than one function sees the pin");
        AST_P0_ANALOG: assert property (p0_analog_path_en[p] |-> (code == PFM_CODE_ALT3) && (p0_pad_oe[p] == 1'b0))
            else $error("analog path enabled without analog selection");
    end

    assign debug_port_en = cur.sel2[PFM_SEL2_DEBUG_BIT];
    assign trace_port_en = cur.sel2[PFM_SEL2_TRACE_BIT];

    // port-1 pins 16..31: one bit hands a whole group to debug or trace
    for (genvar q = 0; q < PFM_P1_PINS; q++) begin : g_p1
        logic own;
        assign own = (q >= PFM_P1_DEBUG_FIRST - PFM_P1_FIRST) ? debug_port_en : trace_port_en;
        assign p1_pad_out[q] = own ? p1_dbg_out[q] : port1_gpio_out[q];
        assign p1_pad_oe[q] = own ? p1_dbg_oe[q] : port1_direction_bits[q];
        assign p1_dbg_in[q] = own ? cur.p1_s2[q] : 1'b0;
        assign port1_gpio_in[q] = own ? 1'b0 : cur.p1_s2[q];
    end

    // test-port inputs taken from their pins only while debug owns them
    assign jtag_tms = p1_dbg_in[P30];
    assign jtag_trst = p1_dbg_in[P31];

    AST_SEL0_RESET: assert property ($past(rst) |-> (cur.sel0 == PFM_RST_SEL0) && (port0_gpio_in == cur.p0_s2))
        else $error("port-0 low select not zero after reset");
    AST_SEL1_RESET: assert property ($past(rst) |-> (port0_high_select == PFM_RST_SEL1))
        else $error("port-0 high select wrong after reset");
    AST_WRITE_ROUTE: assert property ((wr_fire && cur.aw_addr == PFM_ADDR_SEL0 && cur.w_strb == 4'hF)
        |=> (cur.sel0 == $past(cur.w_data)) && axil_rsp.bvalid)
        else $error("select write did not take effect with the response");
    AST_READ_SEL1: assert property ((ar_take && axil_req.araddr == PFM_ADDR_SEL1)
        |=> axil_rsp.rvalid && (axil_rsp.rdata == $past(cur.sel1)) && (axil_rsp.rresp == PFM_RESP_OKAY))
        else $error("read of port-0 high select wrong");
    AST_TRACE_STRAP: assert property ((cur.strap == PFM_STRAP_WAIT3 && ce && !wr_fire && !cur.p1_s2[P20])
        |=> trace_port_en ##1 trace_port_en || $past(wr_fire))
        else $error("trace strap not captured");
    AST_DEBUG_TMS: assert property (debug_port_en |-> (jtag_tms == cur.p1_s2[P30]) && (jtag_trst == cur.p1_s2[P31]))
        else $error("test-port inputs not routed under debug");

endmodule // pfm_pin_mux

// ### rtl/pfm_pkg.sv
// package for the pin function multiplexer: map, reset values, field layout, carriers
package pfm_pkg;
    // pin counts
    localparam int PFM_P0_PINS = 16;
    localparam int PFM_P1_PINS = 16;
    localparam int PFM_P1_FIRST = 16;
    localparam int PFM_P1_DEBUG_FIRST = 26;
    localparam int PFM_P1_PIN20 = 20;
    localparam int PFM_P1_PIN26 = 26;
    localparam int PFM_P1_PIN30 = 30;
    localparam int PFM_P1_PIN31 = 31;

    // register byte addresses
    localparam logic [31:0] PFM_ADDR_SEL0 = 32'hE002_C000;
    localparam logic [31:0] PFM_ADDR_SEL1 = 32'hE002_C004;
    localparam logic [31:0] PFM_ADDR_SEL2 = 32'hE002_C014;

    // values after reset
    localparam logic [31:0] PFM_RST_SEL0 = 32'h0000_0000;
    localparam logic [31:0] PFM_RST_SEL1 = 32'h1540_0000;
    localparam logic [31:0] PFM_RST_SEL2 = 32'h0000_0000;
    localparam logic [15:0] PFM_RST_SYNC = 16'hFFFF;

    // port-1 select register fields; bits 1:0 and 31:28 are reserved and read zero
    localparam int PFM_SEL2_DEBUG_BIT = 2;
    localparam int PFM_SEL2_TRACE_BIT = 3;
    localparam logic [31:0] PFM_SEL2_WMASK = 32'h0FFF_FFFC;

    // two-bit function codes of the port-0 low select register
    localparam logic [1:0] PFM_CODE_GPIO = 2'h0;
    localparam logic [1:0] PFM_CODE_ALT3 = 2'h3;

    // pins whose code 11 is the converter input (4,5,6,8,10,12,13,15)
    localparam logic [15:0] PFM_ANALOG_PINS = 16'hB570;
    // pins whose code 11 is reserved (0,2)
    localparam logic [15:0] PFM_RESERVED_PINS = 16'h0005;

    // bus answers
    localparam logic [1:0] PFM_RESP_OKAY = 2'h0;
    localparam logic [1:0] PFM_RESP_DECERR = 2'h3;

    // start-up sampling of the trace/debug straps
    typedef enum logic [3:0] {
        PFM_STRAP_WAIT1 = 4'b0001,
        PFM_STRAP_WAIT2 = 4'b0010,
        PFM_STRAP_WAIT3 = 4'b0100,
        PFM_STRAP_DONE = 4'b1000
    } pfm_strap_type;

    // register bus, master to slave
    typedef struct packed {
        logic awvalid;
        logic [31:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [31:0] araddr;
        logic rready;
    } pfm_axil_req_type;

    // register bus, slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pfm_axil_rsp_type;

    // whole state of the block
    typedef struct packed {
        logic [31:0] sel0;
        logic [31:0] sel1;
        logic [31:0] sel2;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        pfm_strap_type strap;
        logic [15:0] p0_s1;
        logic [15:0] p0_s2;
        logic [15:0] p1_s1;
        logic [15:0] p1_s2;
    } pfm_state_type;
endpackage

// ### test/pfm_far_side.sv
// far-side model: peripheral drive patterns and port-1 pads with pull-ups
`timescale 1ns/100ps
module pfm_far_side
    import pfm_pkg::*;
(
    // pads that the bench holds low
    input wire logic [PFM_P1_PINS-1:0] p1_pull_low,
    // peripheral side
    output logic [PFM_P0_PINS-1:0][2:0] p0_alt_out,
    output logic [PFM_P0_PINS-1:0][2:0] p0_alt_oe,
    output logic [PFM_P1_PINS-1:0] p1_dbg_out,
    output logic [PFM_P1_PINS-1:0] p1_dbg_oe,
    // port-1 pad levels
    output logic [PFM_P1_PINS-1:0] p1_pad_in
);
    // adjacent codes differ in drive, and every alternate drives, so a route to a neighbouring code shows at the pad
    always_comb begin
        for (int n = 0; n < PFM_P0_PINS; n++) begin
            p0_alt_out[n] = 3'h5 ^ {3{n[0]}};
            p0_alt_oe[n] = 3'h7;
        end
    end
    // debug and trace drive differ from gpio so ownership is visible
    assign p1_dbg_out = 16'hC33C;
    assign p1_dbg_oe = 16'h0FF0;
    // pull-ups: a released pin reads high, never the last driven level
    assign p1_pad_in = ~p1_pull_low;
endmodule // pfm_far_side

// ### test/testbench.sv
// self-checking bench for the pin function multiplexer
`timescale 1ns/100ps
module testbench;
    import pfm_pkg::*;
    localparam logic [15:0] DIR = 16'h00FF;
    localparam logic [15:0] GOUT = 16'h0F0F;
    logic clk = 1'b0;
    logic rst;
    logic ce;
    pfm_axil_req_type axil_req;
    pfm_axil_rsp_type axil_rsp;
    logic [15:0] p0_pad_in, p0_pad_out, p0_pad_oe, port0_gpio_out, port0_direction_bits, port0_gpio_in;
    logic [15:0][2:0] p0_alt_out, p0_alt_oe, p0_alt_in;
    logic [15:0] p0_analog_path_en, p1_pad_in, p1_pad_out, p1_pad_oe, port1_gpio_out, port1_direction_bits;
    logic [15:0] port1_gpio_in, p1_dbg_out, p1_dbg_oe, p1_dbg_in, p1_pull_low;
    logic [31:0] port0_high_select, rd;
    logic jtag_tms, jtag_trst, debug_port_en, trace_port_en;
    logic [1:0] rs;
    int failures = 0;
    int n_checks = 0;

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    pfm_pin_mux uut (.clk(clk), .rst(rst), .ce(ce), .axil_req(axil_req), .axil_rsp(axil_rsp),
        .p0_pad_in(p0_pad_in), .p0_pad_out(p0_pad_out), .p0_pad_oe(p0_pad_oe),
        .port0_gpio_out(port0_gpio_out), .port0_direction_bits(port0_direction_bits),
        .port0_gpio_in(port0_gpio_in), .p0_alt_out(p0_alt_out), .p0_alt_oe(p0_alt_oe),
        .p0_alt_in(p0_alt_in), .p0_analog_path_en(p0_analog_path_en), .port0_high_select(port0_high_select),
        .p1_pad_in(p1_pad_in), .p1_pad_out(p1_pad_out), .p1_pad_oe(p1_pad_oe),
        .port1_gpio_out(port1_gpio_out), .port1_direction_bits(port1_direction_bits),
        .port1_gpio_in(port1_gpio_in), .p1_dbg_out(p1_dbg_out), .p1_dbg_oe(p1_dbg_oe), .p1_dbg_in(p1_dbg_in),
        .jtag_tms(jtag_tms), .jtag_trst(jtag_trst), .debug_port_en(debug_port_en), .trace_port_en(trace_port_en));

    pfm_far_side far (.p1_pull_low(p1_pull_low), .p0_alt_out(p0_alt_out), .p0_alt_oe(p0_alt_oe),
        .p1_dbg_out(p1_dbg_out), .p1_dbg_oe(p1_dbg_oe), .p1_pad_in(p1_pad_in));

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a wait that ran out of its bound ends the run
    task automatic hang();
        failures++;
        test_done();
    endtask

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // requests change just after a rising edge; ready and answer are taken at the edge that moves the beat
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        aw = 1'b0;
        w = 1'b0;
        b = 1'b0;
        r = 2'h0;
        @(posedge clk);
        axil_req.awaddr <= a;
        axil_req.wdata <= d;
        axil_req.wstrb <= 4'hF;
        axil_req.awvalid <= 1'b1;
        axil_req.wvalid <= 1'b1;
        axil_req.bready <= 1'b1;
        for (int i = 0; i < 20 && !b; i++) begin
            @(posedge clk);
            if (aw && w && axil_rsp.bvalid) begin
                b = 1'b1;
                r = axil_rsp.bresp;
            end
            if (!aw && axil_rsp.awready) begin
                aw = 1'b1;
                axil_req.awvalid <= 1'b0;
            end
            if (!w && axil_rsp.wready) begin
                w = 1'b1;
                axil_req.wvalid <= 1'b0;
            end
        end
        axil_req.bready <= 1'b0;
        if (!b) hang();
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t, v;
        t = 1'b0;
        v = 1'b0;
        d = 32'h0000_0000;
        r = 2'h0;
        @(posedge clk);
        axil_req.araddr <= a;
        axil_req.arvalid <= 1'b1;
        axil_req.rready <= 1'b1;
        for (int i = 0; i < 20 && !v; i++) begin
            @(posedge clk);
            if (t && axil_rsp.rvalid) begin
                v = 1'b1;
                d = axil_rsp.rdata;
                r = axil_rsp.rresp;
            end
            if (!t && axil_rsp.arready) begin
                t = 1'b1;
                axil_req.arvalid <= 1'b0;
            end
        end
        axil_req.rready <= 1'b0;
        if (!v) hang();
    endtask

    // expected pad and peripheral view for one select word, all pads high
    task automatic chk_p0(input logic [31:0] s);
        logic [15:0] oe, out, gin, aen;
        logic [15:0][2:0] ain;
        logic [1:0] c;
        for (int n = 0; n < 16; n++) begin
            c = s[2*n+:2];
            ain[n] = 3'h0;
            gin[n] = (c == 2'h0);
            aen[n] = (c == 2'h3) && PFM_ANALOG_PINS[n];
            oe[n] = (c == 2'h0) ? DIR[n] : (c != 2'h3);
            out[n] = (c == 2'h0) ? GOUT[n] : n[0] ^ ~c[1];
            if (c == 2'h3 && !PFM_ANALOG_PINS[n] && !PFM_RESERVED_PINS[n]) begin
                oe[n] = 1'b1;
                out[n] = n[0] ^ 1'b1;
            end
            if (c != 2'h0 && !aen[n] && !PFM_RESERVED_PINS[n] | (c != 2'h3)) ain[n][c - 1] = 1'b1;
        end
        @(negedge clk);
        chk32("p0_pad_oe", oe, p0_pad_oe);
        chk32("p0_pad_out", out & oe, p0_pad_out & oe);
        chk32("port0_gpio_in", gin, port0_gpio_in);
        chk32("p0_alt_in", 32'(ain), 32'(p0_alt_in));
        chk32("p0_alt_in_hi", 32'(ain[15:10]), 32'(p0_alt_in[15:10]));
        chk32("p0_analog_path_en", aen, p0_analog_path_en);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // reset values and default routing
    task automatic t_reset();
        bus_rd(PFM_ADDR_SEL0, rd, rs);
        chk32("sel0", 32'h0000_0000, rd);
        chk2("resp", PFM_RESP_OKAY, rs);
        bus_rd(PFM_ADDR_SEL1, rd, rs);
        chk32("sel1", 32'h1540_0000, rd);
        chk32("port0_high_select", 32'h1540_0000, port0_high_select);
        bus_rd(PFM_ADDR_SEL2, rd, rs);
        chk32("sel2", 32'h0000_0000, rd);
        chk_p0(32'h0000_0000);
    endtask

    // every code on every pin, then a mixed word; routing follows at once
    task automatic t_p0_all();
        logic [31:0] s;
        for (int n = 0; n < 16; n++) begin
            for (int c = 0; c < 4; c++) begin
                s = 32'(c) << (2 * n);
                bus_wr(PFM_ADDR_SEL0, s, rs);
                chk_p0(s);
            end
        end
        bus_wr(PFM_ADDR_SEL0, 32'hE4E4_1B1B, rs);
        chk_p0(32'hE4E4_1B1B);
        bus_rd(PFM_ADDR_SEL0, rd, rs);
        chk32("sel0", 32'hE4E4_1B1B, rd);
    endtask

    // unmapped places answer an error and leave the registers alone
    task automatic t_unmapped();
        bus_wr(32'hE002_C008, 32'hFFFF_FFFF, rs);
        chk2("bresp", PFM_RESP_DECERR, rs);
        bus_rd(32'hE002_C010, rd, rs);
        chk2("rresp", PFM_RESP_DECERR, rs);
        chk32("rdata", 32'h0000_0000, rd);
        bus_rd(PFM_ADDR_SEL1, rd, rs);
        chk32("sel1", 32'h1540_0000, rd);
    endtask

    // clock enable low freezes the synchronisers and refuses every bus beat
    task automatic t_hold();
        @(posedge clk);
        ce <= 1'b0;
        p0_pad_in <= 16'h0000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk32("readies", 32'h0, {axil_rsp.awready, axil_rsp.wready, axil_rsp.arready});
        chk32("port0_gpio_in", 32'h0000_1188, port0_gpio_in);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk32("port0_gpio_in", 32'h0000_0000, port0_gpio_in);
        @(posedge clk);
        p0_pad_in <= 16'hFFFF;
        repeat (2) @(posedge clk);
    endtask

    // debug and trace ownership of port-1
    task automatic t_port1();
        bus_wr(PFM_ADDR_SEL2, 32'hFFFF_FFFF, rs);
        bus_rd(PFM_ADDR_SEL2, rd, rs);
        chk32("sel2", 32'h0FFF_FFFC, rd);
        chk32("ports_en", 32'h3, {debug_port_en, trace_port_en});
        p1_pull_low <= 16'h4000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk32("jtag", 32'h1, {jtag_tms, jtag_trst});
        chk32("p1_pad_oe", 32'h0FF0, p1_pad_oe);
        chk32("port1_gpio_in", 32'h0, port1_gpio_in);
        bus_wr(PFM_ADDR_SEL2, 32'h0000_0004, rs);
        @(negedge clk);
        chk32("p1_pad_oe", 32'h0FFF, p1_pad_oe);
        chk32("port1_gpio_in", 32'h03FF, port1_gpio_in);
        bus_wr(PFM_ADDR_SEL2, 32'h0000_0000, rs);
        @(negedge clk);
        chk32("p1_pad_out", 32'h5A5A, p1_pad_out);
        chk32("jtag_trst", 32'h0, jtag_trst);
        @(posedge clk);
        p1_pull_low <= 16'h0000;
    endtask

    // pin 20 held low across reset hands pins 16 to 25 to trace afterwards
    task automatic t_strap();
        @(posedge clk);
        p1_pull_low <= 16'h0010;
        do_reset();
        repeat (4) @(posedge clk);
        p1_pull_low <= 16'h0000;
        bus_rd(PFM_ADDR_SEL2, rd, rs);
        chk32("sel2", 32'h0000_0008, rd);
        chk32("ports_en", 32'h1, {debug_port_en, trace_port_en});
        bus_rd(PFM_ADDR_SEL0, rd, rs);
        chk32("sel0", 32'h0000_0000, rd);
    endtask

    // main sequence
    initial begin
        axil_req = '0;
        rst = 1'b1;
        ce = 1'b1;
        p0_pad_in = 16'hFFFF;
        port0_gpio_out = GOUT;
        port0_direction_bits = DIR;
        port1_gpio_out = 16'h5A5A;
        port1_direction_bits = 16'hFFFF;
        p1_pull_low = 16'h0000;
        do_reset();
        t_reset();
        t_p0_all();
        t_unmapped();
        t_hold();
        t_port1();
        t_strap();
        test_done();
    end
endmodule // testbench
